// ---- hw/move_decode_pkg.sv ----
package move_decode_pkg;

	// **********************************************************************
	// Opcode fields
	// **********************************************************************
	localparam int          INSTR_W          = 16;
	localparam logic [7:0]  LOAD_IMM_UPPER   = 8'h0e;
	localparam logic [6:0]  STORE_W_UPPER    = 7'h37;
	localparam int          BANK_BIT_POS     = 8;
	localparam int          ADDR_HALF_POS    = 7;

	// Banks used when the opcode asks for the access bank.
	localparam logic [7:0]  ACCESS_LOW_BANK  = 8'h00;
	localparam logic [7:0]  ACCESS_HIGH_BANK = 8'h0f;

	// **********************************************************************
	// Reset values
	// **********************************************************************
	localparam logic [7:0]  W_RESET          = 8'h00;
	localparam logic [15:0] INSTR_RESET      = 16'h0000;
	localparam logic [15:0] ADDR_RESET       = 16'h0000;
	localparam logic [7:0]  DATA_RESET       = 8'h00;

	// **********************************************************************
	// Types
	// **********************************************************************
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
	typedef enum logic [1:0] {OP_NONE, OP_LOAD_IMM, OP_STORE_W} op_t;

	typedef struct packed {
		phase_t      phase;
		op_t         op;
		logic [15:0] instr;
		logic [7:0]  bank;
		logic [7:0]  wReg;
		logic        wWrEn;
		logic        memWrEn;
		logic [15:0] memAddr;
		logic [7:0]  memData;
	} core_state_t;

	// Classifies one program word.
	function automatic op_t decodeOp(input logic [15:0] word);
		if (word[15:8] == LOAD_IMM_UPPER)
			return OP_LOAD_IMM;
		else if (word[15:9] == STORE_W_UPPER)
			return OP_STORE_W;
		else
			return OP_NONE;
	endfunction

	// Picks the target bank from the opcode bank bit and address.
	function automatic logic [7:0] bankFor(input logic [15:0] word, input logic [7:0] bankSel);
		if (word[BANK_BIT_POS])
			return bankSel;
		else if (word[ADDR_HALF_POS])
			return ACCESS_HIGH_BANK;
		else
			return ACCESS_LOW_BANK;
	endfunction

endpackage

// ---- hw/move_literal_and_store_w_decode.sv ----
`timescale 1ns/1ps
// Functional notes
// RQ1 - Store copies W to location; W, flags unchanged.
// RQ2 - Eight-bit address reaches all 256 bank bytes.
// RQ3 - Bank bit zero selects access bank, ignoring bank_select_reg.
// RQ4 - Bank bit one takes bank from bank_select_reg.
// RQ5 - Load places immediate into W; flags untouched.
// RQ6 - Upper byte 0000 1110 decodes load; rest immediate.
// RQ7 - Load: one word, one cycle, W written last.
// RQ8 - Store: one word, one cycle, written fourth phase.
module move_literal_and_store_w_decode
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] instrWord,
	input  wire logic        instrValid,
	input  wire logic [7:0]  bankSelect,
	output logic [1:0]       cyclePhase,
	output logic [7:0]       workingReg,
	output logic             workingWrEn,
	output logic             dataWrEn,
	output logic [15:0]      dataAddr,
	output logic [7:0]       dataOut
);

	// **********************************************************************
	// State
	// **********************************************************************
	// The whole block state lives in one packed struct.
	move_decode_pkg::core_state_t state_r;
	move_decode_pkg::core_state_t state_nxt;

	// Each clk_sys cycle is one phase; four phases make one instruction cycle.
	// No status flag port exists, so neither instruction can disturb flags.
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.wWrEn = 1'b0;
		state_nxt.memWrEn = 1'b0;
		case (state_r.phase)
			move_decode_pkg::PH_DECODE:
			begin
				// An absent word decodes as a no-op so the phase ring never stalls.
				state_nxt.phase = move_decode_pkg::PH_READ;
				state_nxt.instr = instrWord;
				if (instrValid)
					state_nxt.op = move_decode_pkg::decodeOp(instrWord); // RQ6
				else
					state_nxt.op = move_decode_pkg::OP_NONE;
			end
			move_decode_pkg::PH_READ:
			begin
				// The bank is caught in the read phase so a later change cannot tear it.
				state_nxt.phase = move_decode_pkg::PH_PROCESS;
				state_nxt.bank = move_decode_pkg::bankFor(state_r.instr, bankSelect); // RQ3 RQ4
			end
			move_decode_pkg::PH_PROCESS:
			begin
				// Strobes are raised here so they stand exactly during the write phase.
				state_nxt.phase = move_decode_pkg::PH_WRITE;
				if (state_r.op == move_decode_pkg::OP_STORE_W)
				begin
					state_nxt.memWrEn = 1'b1; // RQ8
					state_nxt.memAddr = {state_r.bank, state_r.instr[7:0]}; // RQ2
					state_nxt.memData = state_r.wReg; // RQ1
				end
				if (state_r.op == move_decode_pkg::OP_LOAD_IMM)
					state_nxt.wWrEn = 1'b1; // RQ7
			end
			default:
			begin
				// W takes the immediate at the close of the write phase.
				state_nxt.phase = move_decode_pkg::PH_DECODE;
				if (state_r.op == move_decode_pkg::OP_LOAD_IMM)
					state_nxt.wReg = state_r.instr[7:0]; // RQ5
			end
		endcase
	end

	// Single register stage for the whole state.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r.phase   <= move_decode_pkg::PH_DECODE;
			state_r.op      <= move_decode_pkg::OP_NONE;
			state_r.instr   <= move_decode_pkg::INSTR_RESET;
			state_r.bank    <= move_decode_pkg::ACCESS_LOW_BANK;
			state_r.wReg    <= move_decode_pkg::W_RESET;
			state_r.wWrEn   <= 1'b0;
			state_r.memWrEn <= 1'b0;
			state_r.memAddr <= move_decode_pkg::ADDR_RESET;
			state_r.memData <= move_decode_pkg::DATA_RESET;
		end
		else
			state_r <= state_nxt;
	end

	// **********************************************************************
	// Outputs
	// **********************************************************************
	// Outputs come straight from the state flops.
	assign cyclePhase  = state_r.phase;
	assign workingReg  = state_r.wReg;
	assign workingWrEn = state_r.wWrEn;
	assign dataWrEn    = state_r.memWrEn;
	assign dataAddr    = state_r.memAddr;
	assign dataOut     = state_r.memData;

	// **********************************************************************
	// Assertions
	// **********************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// A store raises the data strobe for exactly its write phase.
	property p_store_strobe;
		(state_r.phase == move_decode_pkg::PH_WRITE) |->
			(dataWrEn == (state_r.op == move_decode_pkg::OP_STORE_W));
	endproperty
	a_store_strobe: assert property (p_store_strobe) else $error("store strobe off phase"); // RQ8

	// Stored data equals W, and W survives the store.
	property p_store_data;
		dataWrEn |-> (dataOut == workingReg) ##1 $stable(workingReg);
	endproperty
	a_store_data: assert property (p_store_data) else $error("store data wrong"); // RQ1

	// Address low byte is the opcode address field.
	property p_addr_low;
		dataWrEn |-> (dataAddr[7:0] == state_r.instr[7:0]);
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("address byte wrong"); // RQ2

	// Bank bit clear picks the access bank halves.
	property p_access_bank;
		(dataWrEn && !state_r.instr[8]) |-> (dataAddr[15:8] == (state_r.instr[7] ?
			move_decode_pkg::ACCESS_HIGH_BANK : move_decode_pkg::ACCESS_LOW_BANK));
	endproperty
	a_access_bank: assert property (p_access_bank) else $error("access bank wrong"); // RQ3

	// Bank bit set takes the bank select value seen in the read phase.
	property p_banked;
		(state_r.phase == move_decode_pkg::PH_READ && state_r.op == move_decode_pkg::OP_STORE_W
			&& state_r.instr[8]) |-> ##2 (dataAddr[15:8] == $past(bankSelect, 2));
	endproperty
	a_banked: assert property (p_banked) else $error("banked address wrong"); // RQ4

	// A load delivers its immediate into W four cycles after decode. A word
	// offered at the release edge is not taken, so that edge is left out.
	property p_load_value;
		(reset_n && state_r.phase == move_decode_pkg::PH_DECODE && instrValid &&
			instrWord[15:8] == move_decode_pkg::LOAD_IMM_UPPER) |->
			##3 workingWrEn ##1 (workingReg == state_r.instr[7:0]);
	endproperty
	a_load_value: assert property (p_load_value) else $error("load value wrong"); // RQ5 RQ6

	// W never changes except at the end of a load's write phase.
	property p_w_stable;
		!workingWrEn |=> $stable(workingReg);
	endproperty
	a_w_stable: assert property (p_w_stable) else $error("W changed unexpectedly"); // RQ1 RQ5

	// Load strobes only in the write phase and never writes memory.
	property p_load_phase;
		workingWrEn |-> (state_r.phase == move_decode_pkg::PH_WRITE) && !dataWrEn;
	endproperty
	a_load_phase: assert property (p_load_phase) else $error("load strobe misplaced"); // RQ7

	// The phase ring closes after four phases. The release edge still finds
	// the flops in reset, so the ring is checked from the next edge on.
	property p_phase_ring;
		(reset_n && state_r.phase == move_decode_pkg::PH_DECODE) |=>
			(state_r.phase == move_decode_pkg::PH_READ) ##1
			(state_r.phase == move_decode_pkg::PH_PROCESS) ##1
			(state_r.phase == move_decode_pkg::PH_WRITE) ##1
			(state_r.phase == move_decode_pkg::PH_DECODE);
	endproperty
	a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken"); // RQ7 RQ8

	// Strobes last one phase, so a stuck enable cannot repeat a write.
	property p_strobe_pulse;
		(workingWrEn || dataWrEn) |=> (!workingWrEn && !dataWrEn);
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long"); // RQ7 RQ8

	// The data strobe never leaves the write phase.
	property p_store_phase;
		dataWrEn |-> (state_r.phase == move_decode_pkg::PH_WRITE);
	endproperty
	a_store_phase: assert property (p_store_phase) else $error("store strobe early"); // RQ8

	// Address and data move only as a store strobe rises and hold between
	// stores; the release edge is left out because reset has just cleared them.
	property p_store_hold;
		(reset_n && !$rose(dataWrEn)) |-> ($stable(dataAddr) && $stable(dataOut));
	endproperty
	a_store_hold: assert property (p_store_hold) else $error("store bus moved"); // RQ1 RQ2

	// A word presented without instrValid never starts an instruction.
	property p_invalid_noop;
		(state_r.phase == move_decode_pkg::PH_DECODE && !instrValid) |=>
			(state_r.op == move_decode_pkg::OP_NONE);
	endproperty
	a_invalid_noop: assert property (p_invalid_noop) else $error("invalid word ran"); // RQ6

	// Words that are neither load nor store raise no strobe at all.
	property p_other_quiet;
		(state_r.op == move_decode_pkg::OP_NONE) |-> (!workingWrEn && !dataWrEn);
	endproperty
	a_other_quiet: assert property (p_other_quiet) else $error("other opcode strobed"); // RQ6

	// **********************************************************************
	// Cover points
	// **********************************************************************
	// Main scenarios that the bench must reach.
	c_load: cover property (workingWrEn ##1 (workingReg == 8'hff));
	c_store_banked: cover property (dataWrEn && state_r.instr[8]);
	c_store_access_high: cover property (dataWrEn && !state_r.instr[8] && state_r.instr[7]);
	c_load_then_store: cover property (workingWrEn ##4 dataWrEn);
	c_store_access_low: cover property (dataWrEn && !state_r.instr[8] && !state_r.instr[7]);

endmodule // move_literal_and_store_w_decode

// ---- test/move_literal_and_store_w_decode_tb_top.sv ----
`timescale 1ns/1ps
module move_literal_and_store_w_decode_tb_top;

	// ****************************************************************
	// Signals and the design
	// ****************************************************************
	logic        clk_sys = 1'b0;
	logic        reset_n;
	logic [15:0] instrWord;
	logic        instrValid;
	logic [7:0]  bankSelect;
	logic [1:0]  cyclePhase;
	logic [7:0]  workingReg;
	logic        workingWrEn;
	logic        dataWrEn;
	logic [15:0] dataAddr;
	logic [7:0]  dataOut;
	logic [15:0] rnd = 16'h0039;
	logic [7:0]  expW;
	int          err_total = 0;
	int          num_checks = 0;

	// Half period of 20 ns gives the 25 MHz core clock.
	always #20 clk_sys = ~clk_sys;

	move_literal_and_store_w_decode i_dut
	(
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.instrWord   (instrWord),
		.instrValid  (instrValid),
		.bankSelect  (bankSelect),
		.cyclePhase  (cyclePhase),
		.workingReg  (workingReg),
		.workingWrEn (workingWrEn),
		.dataWrEn    (dataWrEn),
		.dataAddr    (dataAddr),
		.dataOut     (dataOut)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Fixed-seed shift register, so every run repeats the same traffic.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected target address; bank bit low picks an access bank half.
	function automatic logic [15:0] addrFor(input logic [15:0] w, input logic [7:0] b);
		if (w[8])
			return {b, w[7:0]};
		return {(w[7] ? move_decode_pkg::ACCESS_HIGH_BANK : move_decode_pkg::ACCESS_LOW_BANK),
			w[7:0]};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One instruction; a tempting load word stays valid in the later
	// phases and the bank value flips after its sampling edge, so a
	// decoder that samples at the wrong phase shows up.
	task automatic run(input logic [15:0] w, input logic [7:0] b, input logic v);
		logic ld;
		logic st;
		int   n;
		ld = v && (w[15:8] == 8'h0e);
		st = v && (w[15:9] == 7'h37);
		n = 0;
		while (cyclePhase !== 2'd3 && n < 8)
		begin
			@(negedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
		instrWord <= w;
		bankSelect <= b;
		instrValid <= v;
		@(negedge clk_sys);
		check(16'(cyclePhase), 16'h0000, "decode phase");
		check(16'(workingReg), 16'(expW), "working value");
		check(16'(workingWrEn), 16'h0000, "load strobe idle");
		check(16'(dataWrEn), 16'h0000, "store strobe idle");
		@(posedge clk_sys);
		instrWord <= {8'h0e, ~w[7:0]};
		instrValid <= 1'b1;
		@(posedge clk_sys);
		bankSelect <= ~b;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(16'(cyclePhase), 16'h0003, "write phase");
		check(16'(workingWrEn), 16'(ld), "load strobe");
		check(16'(dataWrEn), 16'(st), "store strobe");
		check(16'(workingReg), 16'(expW), "working held");
		if (st)
		begin
			check(dataAddr, addrFor(w, b), "store address");
			check(16'(dataOut), 16'(expW), "store data");
		end
		if (ld)
			expW = w[7:0];
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	// Corner words first, then random traffic, then a reset in mid-run.
	initial
	begin
		reset_n <= 1'b0;
		instrWord <= 16'h0000;
		instrValid <= 1'b0;
		bankSelect <= 8'h00;
		expW = move_decode_pkg::W_RESET;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		check(dataAddr, 16'h0000, "reset address");
		run(16'h0e5a, 8'h05, 1'b1);
		run(16'h6f10, 8'h05, 1'b1);
		run(16'h0e00, 8'h3c, 1'b1);
		run(16'h6e7f, 8'ha5, 1'b1);
		run(16'h0eff, 8'h11, 1'b1);
		run(16'h6e80, 8'ha5, 1'b1);
		run(16'h6fff, 8'hff, 1'b1);
		run(16'h0e33, 8'h00, 1'b0);
		run(16'h0105, 8'h00, 1'b1);
		run(16'h0f12, 8'h00, 1'b1);
		run(16'h6c44, 8'h07, 1'b1);
		for (int i = 0; i < 300; i++)
		begin
			rnd = lfsr(rnd);
			case (rnd[1:0])
				2'd0: run({8'h0e, rnd[15:8]}, rnd[11:4], rnd[3] | rnd[2]);
				2'd1: run({7'h37, rnd[2], rnd[15:8]}, rnd[11:4], rnd[3] | rnd[4]);
				default: run(rnd, rnd[11:4], 1'b1);
			endcase
		end
		@(posedge clk_sys);
		reset_n <= 1'b0;
		instrValid <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		expW = move_decode_pkg::W_RESET;
		run(16'h6e20, 8'h00, 1'b1);
		run(16'h6e21, 8'h00, 1'b1);
		finish_test();
	end

	// Roughly 1,260 cycles are needed; 20,000 means a hang.
	initial
	begin
		#800000;
		err_total++;
		finish_test();
	end

endmodule // move_literal_and_store_w_decode_tb_top
